// ### fsp_core.sv
/*
 fsp_core: processor-core end. Software drives it over AXI4-Lite;
 it issues control writes, store-program pulses and flash reads.
 Assumes a single-clock AXI4-Lite master on sys_clk_i.
*/
`timescale 1ns/1ps
module fsp_core (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    fsp_link_if.core         lnk,
    input  wire logic [4:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [4:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i
);
    logic        aw_got;
    logic        w_got;
    logic [4:0]  awaddr;
    logic [31:0] wdata;
    logic        ctrl_wr;
    logic [7:0]  ctrl_wdata;
    logic        spm;
    logic        spm_pend;
    logic        ee_write;
    logic [15:0] z_addr;
    logic [15:0] r_data;
    logic [15:0] rd_addr;

    function automatic logic mapped(input logic [4:0] a, input logic rd);
        mapped = (a == fsp_pkg::OFS_CTRL) || (a == fsp_pkg::OFS_ADDR)
              || (a == fsp_pkg::OFS_DATA) || (a == fsp_pkg::OFS_FLASH)
              || (rd ? (a == fsp_pkg::OFS_STAT) : (a == fsp_pkg::OFS_EEWR));
    endfunction

    wire aw_hs      = s_axi_awvalid_i && s_axi_awready_o;
    wire w_hs       = s_axi_wvalid_i && s_axi_wready_o;
    wire wr_fire    = aw_got && w_got && !s_axi_bvalid_o;
    wire next_aw    = (aw_got || aw_hs) && !wr_fire;
    wire next_w     = (w_got || w_hs) && !wr_fire;
    wire next_bv    = wr_fire || (s_axi_bvalid_o && !s_axi_bready_i);
    wire ar_hs      = s_axi_arvalid_i && s_axi_arready_o;
    wire next_rv    = ar_hs || (s_axi_rvalid_o && !s_axi_rready_i);
    wire wr_ok      = mapped(awaddr, 1'b0);
    wire rd_map     = mapped(s_axi_araddr_i, 1'b1);
    wire [31:0] stat = {22'h0, lnk.cpu_halt, lnk.busy, lnk.ctrl_rdata};
    wire [31:0] fl_word = {15'h0, lnk.rd_ok, lnk.rd_data};
    wire [31:0] rd_mux =
        (s_axi_araddr_i == fsp_pkg::OFS_CTRL)  ? {24'h0, lnk.ctrl_rdata} :
        (s_axi_araddr_i == fsp_pkg::OFS_ADDR)  ? {16'h0, z_addr} :
        (s_axi_araddr_i == fsp_pkg::OFS_DATA)  ? {16'h0, r_data} :
        (s_axi_araddr_i == fsp_pkg::OFS_STAT)  ? stat :
        (s_axi_araddr_i == fsp_pkg::OFS_FLASH) ? fl_word : 32'h0;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            aw_got          <= 1'b0;
            w_got           <= 1'b0;
            awaddr          <= 5'h00;
            wdata           <= 32'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= fsp_pkg::RESP_OKAY;
        end else begin
            aw_got          <= next_aw;
            w_got           <= next_w;
            s_axi_awready_o <= !next_aw && !next_bv;
            s_axi_wready_o  <= !next_w && !next_bv;
            s_axi_bvalid_o  <= next_bv;
            if (aw_hs) begin
                awaddr <= s_axi_awaddr_i;
            end
            if (w_hs) begin
                wdata <= s_axi_wdata_i;
            end
            if (wr_fire) begin
                s_axi_bresp_o <= wr_ok ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
            end
        end
    end

    // store-program follows the control write by one cycle: inside window
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_wr    <= 1'b0;
            ctrl_wdata <= fsp_pkg::CTRL_RESET;
            spm_pend   <= 1'b0;
            spm        <= 1'b0;
            ee_write   <= 1'b0;
            z_addr     <= 16'h0000;
            r_data     <= 16'h0000;
            rd_addr    <= 16'h0000;
        end else begin
            ctrl_wr  <= wr_fire && (awaddr == fsp_pkg::OFS_CTRL);
            spm_pend <= wr_fire && (awaddr == fsp_pkg::OFS_CTRL) && wdata[fsp_pkg::GO_BIT];
            spm      <= spm_pend; // R4
            ee_write <= wr_fire && (awaddr == fsp_pkg::OFS_EEWR);
            if (wr_fire && (awaddr == fsp_pkg::OFS_CTRL)) begin
                ctrl_wdata <= wdata[7:0];
            end
            if (wr_fire && (awaddr == fsp_pkg::OFS_ADDR)) begin
                z_addr <= wdata[15:0]; // R11
            end
            if (wr_fire && (awaddr == fsp_pkg::OFS_DATA)) begin
                r_data <= wdata[15:0];
            end
            if (wr_fire && (awaddr == fsp_pkg::OFS_FLASH)) begin
                rd_addr <= wdata[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0;
            s_axi_rresp_o   <= fsp_pkg::RESP_OKAY;
        end else begin
            s_axi_arready_o <= !next_rv;
            s_axi_rvalid_o  <= next_rv;
            if (ar_hs) begin
                s_axi_rdata_o <= rd_mux;
                s_axi_rresp_o <= rd_map ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
            end
        end
    end

    assign lnk.ctrl_wr    = ctrl_wr;
    assign lnk.ctrl_wdata = ctrl_wdata;
    assign lnk.spm        = spm;
    assign lnk.ee_write   = ee_write;
    assign lnk.z_addr     = z_addr;
    assign lnk.r_data     = r_data;
    assign lnk.rd_addr    = rd_addr;
endmodule // fsp_core

// ### fsp_link_if.sv
/*
 fsp_link_if: link between the processor core end and the sequencer.
 Assumes both ends run on the same sys_clk_i.
*/
`timescale 1ns/1ps
interface fsp_link_if (
    input wire logic sys_clk_i
);
    logic        ctrl_wr;
    logic [7:0]  ctrl_wdata;
    logic        spm;
    logic [15:0] z_addr;
    logic [15:0] r_data;
    logic        ee_write;
    logic [15:0] rd_addr;
    logic [7:0]  ctrl_rdata;
    logic        busy;
    logic        cpu_halt;
    logic [15:0] rd_data;
    logic        rd_ok;

    modport seq (
        input  ctrl_wr, ctrl_wdata, spm, z_addr, r_data, ee_write, rd_addr,
        output ctrl_rdata, busy, cpu_halt, rd_data, rd_ok
    );
    modport core (
        output ctrl_wr, ctrl_wdata, spm, z_addr, r_data, ee_write, rd_addr,
        input  ctrl_rdata, busy, cpu_halt, rd_data, rd_ok
    );
endinterface // fsp_link_if

// ### fsp_link_sva.sv
/*
 fsp_link_sva: assertions on the link between the core end and the sequencer.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fsp_link_sva #(
    parameter int PAGE_WORDS   = 32,
    parameter int NO_READ_WHILE_WRITE_SECTION_FIRST   = 12,
    parameter int ERASE_CYCLES = 200,
    parameter int WRITE_CYCLES = 200
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        ctrl_wr,
    input wire logic [7:0]  ctrl_wdata,
    input wire logic        spm,
    input wire logic [15:0] z_addr,
    input wire logic [15:0] rd_addr,
    input wire logic [7:0]  ctrl_rdata,
    input wire logic        busy,
    input wire logic        cpu_halt,
    input wire logic        rd_ok,
    input wire logic        op_done_o,
    input wire logic        cmd_expired_o
);
    localparam int PAGE_LSB = $clog2(PAGE_WORDS) + 1;
    logic [15:0] busy_len;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // run length of busy, compared when it falls
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !busy) begin
            busy_len <= 16'h0000;
        end else begin
            busy_len <= busy_len + 16'h0001;
        end
    end
    AST_ERASE_START: assert property (!busy && ctrl_wr && ctrl_wdata[6:0] == fsp_pkg::CMD_ERASE
        ##1 spm |=> busy) else $error("erase did not start");
    AST_WRITE_START: assert property (!busy && ctrl_wr && ctrl_wdata[6:0] == fsp_pkg::CMD_WRITE
        ##1 spm |=> busy) else $error("page write did not start");
    AST_HALT_NO_READ_WHILE_WRITE_SECTION: assert property ($rose(busy) && (int'(z_addr) >> PAGE_LSB) >= NO_READ_WHILE_WRITE_SECTION_FIRST
        |-> cpu_halt) else $error("no halt for no-rww target");
    AST_HALT_ONLY_BUSY: assert property (cpu_halt |-> busy)
        else $error("halt outside an operation");
    AST_NO_READ_WHILE_WRITE_SECTION_READABLE: assert property (busy && !cpu_halt
        && int'(rd_addr) >= NO_READ_WHILE_WRITE_SECTION_FIRST * PAGE_WORDS ##1 $stable(rd_addr) |-> rd_ok)
        else $error("no-rww read refused during rww operation");
    AST_CMD_EXPIRES: assert property (!busy && ctrl_wr && ctrl_wdata == fsp_pkg::CMD_LOAD
        ##1 !spm [*4] |-> ##[0:3] cmd_expired_o) else $error("armed command never expired");
    AST_EXPIRE_CLEARS: assert property ($rose(cmd_expired_o)
        |-> ##[0:1] !ctrl_rdata[fsp_pkg::EN_BIT]) else $error("expired command still armed");
    AST_OP_LENGTH: assert property ($fell(busy)
        |-> busy_len == ERASE_CYCLES || busy_len == WRITE_CYCLES)
        else $error("operation length wrong");
    AST_DONE_PULSE: assert property ($fell(busy) |-> ##[0:1] op_done_o)
        else $error("no done pulse at operation end");
endmodule // fsp_link_sva

// ### fsp_pkg.sv
/*
 fsp_pkg: constants and types shared by both ends of the flash
 self-programming sequencer. Assumes nothing of its surroundings.
*/
package fsp_pkg;
    // command patterns in the program control register
    localparam logic [6:0] CMD_ERASE    = 7'h03;
    localparam logic [6:0] CMD_WRITE    = 7'h05;
    localparam logic [7:0] CMD_LOAD     = 8'h01;
    localparam logic [7:0] CMD_REENABLE = 8'h11;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam int         EN_BIT       = 0;
    localparam int         RWW_BUSY_BIT = 6;
    // cycles after a control write in which the store-program may come
    localparam logic [2:0] SPM_WINDOW   = 3'h4;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // z-pointer is a byte address; word field starts at bit 1
    localparam int         Z_WORD_LSB   = 1;
    // register map of the core end, byte offsets
    localparam logic [4:0] OFS_CTRL  = 5'h00;
    localparam logic [4:0] OFS_ADDR  = 5'h04;
    localparam logic [4:0] OFS_DATA  = 5'h08;
    localparam logic [4:0] OFS_EEWR  = 5'h0c;
    localparam logic [4:0] OFS_STAT  = 5'h10;
    localparam logic [4:0] OFS_FLASH = 5'h14;
    localparam int         GO_BIT    = 8;
    localparam int         RDOK_BIT  = 16;
    localparam int         BUSY_BIT  = 8;
    localparam int         HALT_BIT  = 9;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_ERASE = 3'h2,
        ST_WRITE = 3'h4
    } fsp_state_type;
endpackage

// ### fsp_seq.sv
/*
 fsp_seq: flash self-programming sequencer (device end). Holds the
 program control register, the temporary page buffer and the flash.
 Assumes the core drives the link synchronously on sys_clk_i.
*/
// How it works
// R1 - erase pattern plus store-program erases addressed page
// R2 - load pattern stores data pair at word field
// R3 - write pattern plus store-program writes buffer to page
// R4 - store-program must follow within four cycles
// R5 - no-rww section stays readable during rww operations
// R6 - no-rww target halts the core until done
// R7 - buffer cleared on write, re-enable, reset
// R8 - each buffer word loaded once per clearing
// R9 - eeprom write during loading discards buffer
// R10 - buffer fill before erase or after erase
// R11 - erase and write use the same page
// R12 - buffer words loadable in any order
// R13 - one word per store-program
// R14 - software keeps unchanged words across erase
// R15 - software re-enables rww after erase or write
// R16 - late store-program finds the command cleared
`timescale 1ns/1ps
module fsp_seq #(
    parameter int PAGE_WORDS   = 32,
    parameter int PAGES        = 16,
    parameter int NO_READ_WHILE_WRITE_SECTION_FIRST   = 12,
    parameter int ERASE_CYCLES = 200,
    parameter int WRITE_CYCLES = 200
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    fsp_link_if.seq   lnk,
    output logic      op_done_o,
    output logic      cmd_expired_o
);
    localparam int WB = $clog2(PAGE_WORDS);
    localparam int PB = $clog2(PAGES);
    localparam int FW = WB + PB;
    localparam int Z_PG_LSB = fsp_pkg::Z_WORD_LSB + WB;
    localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYCLES - 1);
    localparam logic [15:0] WRITE_LAST = 16'(WRITE_CYCLES - 1);
    localparam logic [PB-1:0] NO_READ_WHILE_WRITE_SECTION_PAGE = PB'(NO_READ_WHILE_WRITE_SECTION_FIRST);

    fsp_pkg::fsp_state_type state;
    logic [7:0]            ctrl;
    logic [2:0]            win;
    logic [15:0]           cnt;
    logic [PB-1:0]         op_page;
    logic                  op_no_read_while_write_section;
    logic                  rww_blocked;
    logic                  busy;
    logic                  halt;
    logic [15:0]           rd_data;
    logic                  rd_ok;
    logic [PAGE_WORDS-1:0] loaded;
    logic [15:0]           buf_mem [PAGE_WORDS];
    logic [15:0]           flash [PAGES*PAGE_WORDS];

    function automatic logic in_no_read_while_write_section(input logic [PB-1:0] page);
        in_no_read_while_write_section = (page >= NO_READ_WHILE_WRITE_SECTION_PAGE);
    endfunction

    wire idle     = (state == fsp_pkg::ST_IDLE);
    wire armed    = ctrl[fsp_pkg::EN_BIT] && (win != 3'h0);
    wire go       = lnk.spm && armed && idle;
    wire do_erase = go && (ctrl[6:0] == fsp_pkg::CMD_ERASE); // R1
    wire do_write = go && (ctrl[6:0] == fsp_pkg::CMD_WRITE); // R3
    wire do_load  = go && (ctrl == fsp_pkg::CMD_LOAD); // R2
    wire do_reen  = go && (ctrl == fsp_pkg::CMD_REENABLE);
    wire expire   = armed && (win == 3'h1) && !go; // R4
    // erase ignores all but the page field; write also takes only it
    wire [PB-1:0] z_page = lnk.z_addr[Z_PG_LSB +: PB]; // R1 R3
    wire [WB-1:0] z_word = lnk.z_addr[fsp_pkg::Z_WORD_LSB +: WB]; // R2
    wire [PB-1:0] rd_page = lnk.rd_addr[WB +: PB];
    wire [FW-1:0] rd_idx  = lnk.rd_addr[FW-1:0];
    wire op_end   = !idle && (cnt == 16'h0000);
    // no second load to a word until cleared; first value kept
    wire load_ok  = do_load && !loaded[z_word]; // R8 R12
    wire buf_clr  = (state == fsp_pkg::ST_WRITE && op_end) || do_reen
                    || (lnk.ee_write && |loaded); // R7 R9
    wire start    = do_erase || do_write;
    wire start_no_read_while_write_section = in_no_read_while_write_section(z_page);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl <= fsp_pkg::CTRL_RESET;
            win  <= 3'h0;
        end else if (lnk.ctrl_wr && idle) begin
            ctrl <= lnk.ctrl_wdata;
            win  <= fsp_pkg::SPM_WINDOW; // R4
        end else if (expire) begin
            ctrl <= fsp_pkg::CTRL_RESET; // R16
            win  <= 3'h0;
        end else if (go) begin
            // erase and write keep the enable bit up until done
            if (!start) begin
                ctrl <= fsp_pkg::CTRL_RESET;
            end
            win <= 3'h0;
        end else begin
            if (op_end) begin
                ctrl <= fsp_pkg::CTRL_RESET;
            end
            if (win != 3'h0) begin
                win <= win - 3'h1;
            end
        end
    end

    // operations may start from an empty or a filled buffer alike
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state   <= fsp_pkg::ST_IDLE;
            cnt     <= 16'h0000;
            op_page <= '0;
            op_no_read_while_write_section <= 1'b0;
        end else begin
            case (state)
                fsp_pkg::ST_IDLE: begin
                    if (do_erase) begin // R10
                        state <= fsp_pkg::ST_ERASE;
                        cnt   <= ERASE_LAST;
                    end else if (do_write) begin // R10
                        state <= fsp_pkg::ST_WRITE;
                        cnt   <= WRITE_LAST;
                    end
                    if (start) begin
                        op_page <= z_page;
                        op_no_read_while_write_section <= start_no_read_while_write_section;
                    end
                end
                fsp_pkg::ST_ERASE, fsp_pkg::ST_WRITE: begin
                    if (op_end) begin
                        state <= fsp_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= fsp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            busy        <= 1'b0;
            halt        <= 1'b0;
            rww_blocked <= 1'b0;
            op_done_o   <= 1'b0;
            cmd_expired_o <= 1'b0;
        end else begin
            busy          <= start || (!idle && !op_end);
            op_done_o     <= op_end;
            cmd_expired_o <= expire;
            if (start && start_no_read_while_write_section) begin
                halt <= 1'b1; // R6
            end else if (op_end) begin
                halt <= 1'b0; // R6
            end
            // rww stays unreadable until software re-enables it
            if (start && !start_no_read_while_write_section) begin
                rww_blocked <= 1'b1;
            end else if (do_reen) begin
                rww_blocked <= 1'b0;
            end
        end
    end

    // load after clear in the same cycle survives: set wins
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            loaded <= '0; // R7
        end else begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                if (load_ok && (z_word == WB'(i))) begin
                    loaded[i] <= 1'b1; // R13
                end else if (buf_clr) begin
                    loaded[i] <= 1'b0; // R7 R9
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (load_ok) begin
            buf_mem[z_word] <= lnk.r_data; // R2 R13
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (op_end) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                if (state == fsp_pkg::ST_ERASE) begin
                    flash[int'(op_page) * PAGE_WORDS + i] <= fsp_pkg::ERASED_WORD;
                end else begin
                    flash[int'(op_page) * PAGE_WORDS + i] <=
                        loaded[i] ? buf_mem[i] : fsp_pkg::ERASED_WORD; // R3
                end
            end
        end
    end

    // no-rww pages always readable; rww pages only when not blocked
    wire rd_allow = in_no_read_while_write_section(rd_page) || !rww_blocked; // R5
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rd_data <= fsp_pkg::ERASED_WORD;
            rd_ok   <= 1'b0;
        end else begin
            rd_ok   <= rd_allow; // R5
            rd_data <= rd_allow ? flash[rd_idx] : fsp_pkg::ERASED_WORD;
        end
    end

    assign lnk.ctrl_rdata = {ctrl[7], rww_blocked, ctrl[5:0]};
    assign lnk.busy       = busy;
    assign lnk.cpu_halt   = halt;
    assign lnk.rd_data    = rd_data;
    assign lnk.rd_ok      = rd_ok;
endmodule // fsp_seq

// ### tb_top.sv
/*
 tb_top: drives the core end over AXI4-Lite and compares flash contents
 with an integer model. Assumes both ends share sys_clk_i.
*/
`timescale 1ns/1ps
module tb_top;
    localparam int PW = 4;
    localparam int NF = 2;
    localparam int OPC = 16;
    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [4:0]  awaddr    = 5'h00;
    logic [4:0]  araddr    = 5'h00;
    logic [31:0] wdata     = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, op_done, cmd_exp;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int          n_errors = 0, checks = 0, seed = 6, cyc = 0, s;
    int          flash [PW*4];
    int          pbuf [PW];
    always #12.5 sys_clk_i = ~sys_clk_i;
    fsp_link_if lnk (.sys_clk_i(sys_clk_i));
    fsp_seq #(.PAGE_WORDS(PW), .PAGES(4), .NO_READ_WHILE_WRITE_SECTION_FIRST(NF), .ERASE_CYCLES(OPC),
        .WRITE_CYCLES(OPC)) fsp_seq_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lnk(lnk.seq),
        .op_done_o(op_done), .cmd_expired_o(cmd_exp));
    fsp_core fsp_core_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lnk(lnk.core),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    fsp_link_sva #(.PAGE_WORDS(PW), .NO_READ_WHILE_WRITE_SECTION_FIRST(NF), .ERASE_CYCLES(OPC), .WRITE_CYCLES(OPC))
        fsp_link_sva_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ctrl_wr(lnk.ctrl_wr),
        .ctrl_wdata(lnk.ctrl_wdata), .spm(lnk.spm), .z_addr(lnk.z_addr), .rd_addr(lnk.rd_addr),
        .ctrl_rdata(lnk.ctrl_rdata), .busy(lnk.busy), .cpu_halt(lnk.cpu_halt),
        .rd_ok(lnk.rd_ok), .op_done_o(op_done), .cmd_expired_o(cmd_exp));
    task automatic finish_test();
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] d);
        @(posedge sys_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge sys_clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rdr(logic [4:0] a);
        @(posedge sys_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge sys_clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic cmd(logic [7:0] c, int z);
        wr(fsp_pkg::OFS_ADDR, 32'(z));
        wr(fsp_pkg::OFS_CTRL, {23'h0, 1'b1, c});
    endtask
    task automatic reen();
        cmd(fsp_pkg::CMD_REENABLE, 0);
        pbuf = '{default: -1};
    endtask
    task automatic load(int p, int w);
        int d;
        d = $random(seed) & 32'hffff;
        wr(fsp_pkg::OFS_DATA, 32'(d));
        cmd(fsp_pkg::CMD_LOAD, (p * PW + w) * 2);
        if (pbuf[w] < 0) pbuf[w] = d;
    endtask
    task automatic fread(int a);
        wr(fsp_pkg::OFS_FLASH, 32'(a));
        rdr(fsp_pkg::OFS_FLASH);
    endtask
    // page operation; peek >= 0 reads that word while the operation runs
    task automatic pgop(logic [6:0] c, int p, int peek);
        int n, z;
        // erase ignores the pattern's top bit and the pointer's word bits
        z = p * PW * 2 + ((c == fsp_pkg::CMD_ERASE) ? ($random(seed) & (2 * PW - 1)) : 0);
        cmd({1'($random(seed)), c}, z);
        rdr(fsp_pkg::OFS_STAT);
        check("busy and halt", 32'({rd[fsp_pkg::HALT_BIT], rd[fsp_pkg::BUSY_BIT]}),
            (p >= NF) ? 32'h3 : 32'h1);
        if (peek >= 0) begin
            fread(peek);
            check("read during op", rd, 32'h10000 | flash[peek]);
        end
        for (n = 0; n < 80 && op_done !== 1'b1; n++) @(posedge sys_clk_i);
        check("op done", 32'(op_done), 32'h1);
        for (n = 0; n < PW; n++) begin
            flash[p*PW+n] = (c == fsp_pkg::CMD_ERASE || pbuf[n] < 0) ? 32'hffff : pbuf[n];
        end
        if (c == fsp_pkg::CMD_WRITE) pbuf = '{default: -1};
    endtask
    task automatic chk_page(int p);
        for (int w = 0; w < PW; w++) begin
            fread(p * PW + w);
            check("flash word", rd, 32'h10000 | flash[p*PW+w]);
        end
    endtask
    initial begin
        pbuf = '{default: -1};
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rdr(fsp_pkg::OFS_STAT);
        check("stat after reset", rd, 32'h0);
        rdr(5'h18);
        check("unmapped read resp", 32'(rresp), 32'(fsp_pkg::RESP_SLVERR));
        wr(fsp_pkg::OFS_STAT, 32'h1);
        check("stat write resp", 32'(resp), 32'(fsp_pkg::RESP_SLVERR));
        // no-rww page, fill after erase in a scattered order
        pgop(fsp_pkg::CMD_ERASE, 3, -1);
        s = $random(seed) & 3;
        for (int w = 0; w < PW; w++) load(3, (w * 3 + s) % PW);
        pgop(fsp_pkg::CMD_WRITE, 3, -1);
        chk_page(3);
        // rww page, partial fill before erase, no-rww read meanwhile
        load(1, 0);
        load(1, 2);
        pgop(fsp_pkg::CMD_ERASE, 1, 3 * PW + 1);
        fread(PW);
        check("blocked rww read", rd, 32'h0000ffff);
        pgop(fsp_pkg::CMD_WRITE, 1, -1);
        reen();
        chk_page(1);
        // buffer cleared by eeprom write, re-enable, write end, reset
        for (int k = 0; k < 4; k++) begin
            load(1, k);
            if (k == 0) wr(fsp_pkg::OFS_EEWR, 32'h1);
            if (k == 1) reen();
            if (k == 2) pgop(fsp_pkg::CMD_WRITE, 1, -1);
            if (k == 3) begin
                rst_i <= 1'b1;
                repeat (2) @(posedge sys_clk_i);
                rst_i <= 1'b0;
                repeat (2) @(posedge sys_clk_i);
            end
            if (k != 2) pbuf = '{default: -1};
            pgop(fsp_pkg::CMD_WRITE, 1, -1);
            reen();
            chk_page(1);
        end
        // command armed without a store-program times out
        wr(fsp_pkg::OFS_CTRL, {24'h0, fsp_pkg::CMD_LOAD});
        for (s = 0; s < 8 && cmd_exp !== 1'b1; s++) @(posedge sys_clk_i);
        check("expire pulse", 32'(cmd_exp), 32'h1);
        rdr(fsp_pkg::OFS_CTRL);
        check("expired ctrl", rd, 32'h0);
        finish_test();
    end
endmodule // tb_top
